// File: include/hpc_pkg.sv
// Shared constants and types for the host port pin control block.
// Assumes a single clock domain; all pins arrive synchronous to mclk.
package hpc_pkg;
  // Width of the host address presented on the shared pins
  localparam int ADDR_W = 16;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic ENABLED_RST = 1'b0;
  localparam logic PULLUP_RST = 1'b1;
  localparam logic IRQ_N_RST = 1'b1;
  localparam logic READY_RST = 1'b0;
  localparam logic OE_RST = 1'b0;
  // Previous-level reset values for the edge detectors
  localparam logic DEVRST_PREV_RST = 1'b0;
  localparam logic STRB_PREV_RST = 1'b0;
  // Level of the direction select that means a read
  localparam logic RW_READ = 1'b1;

  // Transfer sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } hpc_state_type;

  // One host access handed to the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] sel;
  } hpc_access_type;

  // A three-state pin: level and drive enable
  typedef struct packed {
    logic out;
    logic oe;
  } hpc_pin_type;

  // Complete state of the top module
  typedef struct packed {
    hpc_state_type st;
    logic enabled;
    logic pullup_en;
    logic [ADDR_W-1:0] addr;
    hpc_access_type acc;
    hpc_pin_type rdy;
    hpc_pin_type irq;
  } hpc_regs_type;

  localparam hpc_access_type ACC_RST = '{valid: 1'b0, write: 1'b0,
                                         sel: 2'b00};
endpackage : hpc_pkg

// File: logic/hpc_edge.sv
// Rising and falling edge detector for a synchronous level.
// Assumes the input is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module hpc_edge #(
  parameter logic PREV_RST = 1'b0
) (
  input wire logic mclk,    // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic clk_en,  // Freezes state while low
  input wire logic sig,     // Level to watch
  output logic rise,        // High in the cycle sig first reads 1
  output logic fall         // High in the cycle sig first reads 0
);
  logic prev_q;

  // Remember last cycle's level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_q <= PREV_RST;
    end else if (clk_en) begin
      prev_q <= sig;
    end
  end

  // Compare against the remembered level
  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;
endmodule : hpc_edge
`default_nettype wire

// File: logic/hpc_top.sv
// Pin-level control of the parallel host port: enable latch, address
// strobe, direction, ready and the shared interrupt / timer pin.
// Assumes all pins are synchronous to mclk and a core that acknowledges
// each handed-over access with a one-cycle core_ack.
//
// Overview of operation
// - A falling address strobe loads the presented address into the address register.
// - The read/write select level taken at strobe start sets the access direction.
// - Ready drops while an access is in progress and returns once the core finishes.
// - Ready stops driving whenever the output-disable input is low.
// - The interrupt pin is driven high while the device reset is held.
// - With the port disabled the interrupt pin may carry the second timer output.
// - The interrupt / timer pin stops driving whenever the output-disable input is low.
// - Module select is sampled at the rising edge of device reset and high enables the port.
// - A low or open module select at reset leaves the port disabled.
// - After that sample module select is ignored until the next device reset or system reset.
// - Pullups on address strobe and direction are on only while the port is disabled.
// - The two data strobes gated by chip select time each transfer.
// - The two register select bits taken at strobe start choose one of four registers.
`timescale 1ns/1ps
`default_nettype none
module hpc_top (
  input wire logic mclk,                  // System clock, 50 MHz
  input wire logic sys_rst,               // Synchronous reset, high
  input wire logic clk_en,                // Freezes all state while low
  input wire logic device_reset_n,        // Processor reset pin, low
  input wire logic port_module_select,    // Sampled at reset release
  input wire logic port_chip_select_n,    // Port select, low
  input wire logic host_data_strobe_a,    // Data strobe a, low
  input wire logic host_data_strobe_b,    // Data strobe b, low
  input wire logic host_addr_strobe_n,    // Address strobe, low
  input wire logic host_read_write_sel,   // High reads, low writes
  input wire logic reg_select_bit0,       // Register select, bit 0
  input wire logic reg_select_bit1,       // Register select, bit 1
  input wire logic [hpc_pkg::ADDR_W-1:0] host_addr_bus, // Shared pins
  input wire logic emul_output_disable_n, // Low floats outputs
  input wire logic host_irq_req,          // Core asks to interrupt host
  input wire logic timer_b_output,        // Second timer output level
  input wire logic timer_pin_sel,         // Route timer to irq pin
  input wire logic core_ack,              // Core finished the access
  output hpc_pkg::hpc_access_type access, // Access pulse to the core
  output logic [hpc_pkg::ADDR_W-1:0] host_address_reg, // Address reg
  output hpc_pkg::hpc_pin_type host_port_ready, // Ready pin
  output hpc_pkg::hpc_pin_type host_irq_n,      // Irq / timer pin
  output logic port_enabled,              // Port enable latch
  output logic pullup_en                  // Pullup enable for inputs
);
  import hpc_pkg::*;

  hpc_regs_type r_q;
  hpc_regs_type r_d;
  logic strb;
  logic strb_rise;
  logic as_fall;
  logic devrst_rise;

  // Internal data strobe: either strobe low while selected
  assign strb = ~port_chip_select_n &
                (~host_data_strobe_a | ~host_data_strobe_b);

  // Edge detectors for reset release, data strobe and address strobe
  hpc_edge #(.PREV_RST(DEVRST_PREV_RST)) u_rst_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sig(device_reset_n),
    .rise(devrst_rise),
    .fall()
  );

  hpc_edge #(.PREV_RST(STRB_PREV_RST)) u_strb_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sig(strb),
    .rise(strb_rise),
    .fall()
  );

  hpc_edge #(.PREV_RST(STRB_PREV_RST)) u_as_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sig(~host_addr_strobe_n),
    .rise(as_fall),
    .fall()
  );

  // Next-state logic for the whole block
  always_comb begin
    r_d = r_q;
    r_d.acc.valid = 1'b0;
    // Enable latch: only the reset release edge may change it
    if (devrst_rise) begin
      r_d.enabled = port_module_select;
    end
    r_d.pullup_en = ~r_d.enabled;
    // Address capture on address strobe
    if (r_q.enabled && as_fall) begin
      r_d.addr = host_addr_bus;
    end
    // Transfer sequencer
    case (r_q.st)
      ST_IDLE: begin
        if (r_q.enabled && strb_rise) begin
          r_d.acc.valid = 1'b1;
          r_d.acc.write = (host_read_write_sel != RW_READ);
          r_d.acc.sel = {reg_select_bit1, reg_select_bit0};
          r_d.st = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (core_ack || !r_q.enabled) begin
          r_d.st = ST_IDLE;
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
    // Ready only when idle and the port is in use
    r_d.rdy.out = r_d.enabled && (r_d.st == ST_IDLE);
    r_d.rdy.oe = emul_output_disable_n;
    // Interrupt / timer pin
    if (!device_reset_n) begin
      r_d.irq.out = 1'b1;
    end else if (!r_q.enabled && timer_pin_sel) begin
      r_d.irq.out = timer_b_output;
    end else begin
      r_d.irq.out = ~host_irq_req;
    end
    r_d.irq.oe = emul_output_disable_n;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q.st <= ST_IDLE;
      r_q.enabled <= ENABLED_RST;
      r_q.pullup_en <= PULLUP_RST;
      r_q.addr <= ADDR_RST;
      r_q.acc <= ACC_RST;
      r_q.rdy.out <= READY_RST;
      r_q.rdy.oe <= OE_RST;
      r_q.irq.out <= IRQ_N_RST;
      r_q.irq.oe <= OE_RST;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign access = r_q.acc;
  assign host_address_reg = r_q.addr;
  assign host_port_ready = r_q.rdy;
  assign host_irq_n = r_q.irq;
  assign port_enabled = r_q.enabled;
  assign pullup_en = r_q.pullup_en;

  // Checks next to the logic they guard
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  addr_capture_a: assert property (
    clk_en && r_q.enabled && as_fall |=> r_q.addr == $past(host_addr_bus))
    else $error("address strobe did not load the address register");

  dir_capture_a: assert property (
    clk_en && r_q.enabled && strb_rise && r_q.st == ST_IDLE |=>
      r_q.acc.valid && r_q.acc.write == !$past(host_read_write_sel))
    else $error("access direction not taken from read/write select");

  ready_busy_a: assert property (
    r_q.acc.valid |-> !r_q.rdy.out ##1 (!r_q.rdy.out || $past(core_ack)))
    else $error("ready high while an access is in progress");

  ready_off_a: assert property (
    clk_en && !emul_output_disable_n |=> !r_q.rdy.oe)
    else $error("ready driven while outputs disabled");

  irq_reset_a: assert property (
    clk_en && !device_reset_n |=> r_q.irq.out)
    else $error("interrupt pin not high during device reset");

  timer_route_a: assert property (
    clk_en && device_reset_n && !r_q.enabled && timer_pin_sel |=>
      r_q.irq.out == $past(timer_b_output))
    else $error("timer output not routed to interrupt pin");

  irq_off_a: assert property (
    clk_en && !emul_output_disable_n |=> !r_q.irq.oe)
    else $error("interrupt pin driven while outputs disabled");

  enable_sample_a: assert property (
    clk_en && devrst_rise |=> r_q.enabled == $past(port_module_select))
    else $error("module select not sampled at reset release");

  enable_hold_a: assert property (
    clk_en && !devrst_rise |=> $stable(r_q.enabled))
    else $error("enable latch changed outside reset release");

  pullup_link_a: assert property (
    clk_en |=> r_q.pullup_en == !r_q.enabled)
    else $error("pullups not tied to disabled state");

  disabled_quiet_a: assert property (
    clk_en && !r_q.enabled |=> !r_q.acc.valid)
    else $error("access started while port disabled");

  addr_hold_a: assert property (
    clk_en && !r_q.enabled |=> $stable(r_q.addr))
    else $error("address register changed while port disabled");

  disable_sample_a: assert property (
    clk_en && devrst_rise && !port_module_select |=> !r_q.enabled)
    else $error("port enabled although module select was low");

  sel_capture_a: assert property (
    clk_en && r_q.enabled && strb_rise && r_q.st == ST_IDLE |=>
      r_q.acc.sel == $past({reg_select_bit1, reg_select_bit0}))
    else $error("register select not taken at strobe start");

  strobe_only_a: assert property (
    clk_en && !strb_rise |=> !r_q.acc.valid)
    else $error("access started without a data strobe");

  ready_return_a: assert property (
    clk_en && r_q.st == ST_BUSY && core_ack && r_q.enabled &&
      !devrst_rise |=> r_q.rdy.out)
    else $error("ready not back after the core finished");
endmodule : hpc_top
`default_nettype wire

// File: tb/hpc_host_model.sv
// Host processor model: drives strobes, selects and address pins.
// Assumes registered port outputs; drives just after rising mclk.
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
  input wire logic mclk,            // System clock
  input wire logic rdy,             // Ready pin level
  output logic cs_n = 1'b1,         // Chip select, low
  output logic ds_a_n = 1'b1,       // Data strobe a, low
  output logic ds_b_n = 1'b1,       // Data strobe b, low
  output logic as_n = 1'b1,         // Address strobe, low
  output logic rw = 1'b1,           // Direction select
  output logic [1:0] sel = 2'b00,   // Register select bits
  output logic [15:0] bus = 16'h0000 // Shared address pins
);
  import hpc_pkg::*;
  // One address strobe; released pins show the inverse value
  task automatic addr_cycle(input logic [15:0] a);
    @(posedge mclk);
    as_n <= 1'b0;
    bus <= a;
    @(posedge mclk);
    as_n <= 1'b1;
    bus <= ~a;
    @(posedge mclk);
  endtask : addr_cycle
  // One data transfer held until ready returns high
  task automatic xfer(input logic w, input logic [1:0] s, output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    cs_n <= 1'b0;
    rw <= w ? ~RW_READ : RW_READ;
    sel <= s;
    if (s[0]) begin
      ds_b_n <= 1'b0;
    end else begin
      ds_a_n <= 1'b0;
    end
    @(posedge mclk);
    while (rdy !== 1'b0 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 8);
    while (rdy !== 1'b1 && n < 30) begin
      @(posedge mclk);
      n++;
    end
    ok = ok && (n < 30);
    ds_a_n <= 1'b1;
    ds_b_n <= 1'b1;
    cs_n <= 1'b1;
    sel <= ~s;
    @(posedge mclk);
  endtask : xfer
endmodule : hpc_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the host port pin control block.
// Assumes the host model above and a core that acks after 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hpc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, device_reset_n = 1'b0;
  logic port_module_select = 1'b1, emul_output_disable_n = 1'b1;
  logic host_irq_req = 1'b1, timer_b_output = 1'b0;
  logic timer_pin_sel = 1'b0, core_ack = 1'b0, ok, clk_en = 1'b1;
  logic cs_n, ds_a_n, ds_b_n, as_n, rw, port_enabled, pullup_en;
  logic [1:0] sel;
  logic [15:0] bus, host_address_reg;
  hpc_access_type access;
  hpc_pin_type host_port_ready, host_irq_n;
  int failures = 0, total_checks = 0, nval = 0, ack_cnt = 0;
  // Rows: write, select, address
  localparam logic [18:0] ROWS [8] = '{{3'b100, 16'hFFFF},
    {3'b001, 16'h0000}, {3'b110, 16'hA55A}, {3'b011, 16'h5AA5},
    {3'b000, 16'h0001}, {3'b101, 16'h8000}, {3'b010, 16'h1234},
    {3'b111, 16'hFEDC}};
  hpc_top u_hpc_top (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .device_reset_n(device_reset_n), .port_module_select(port_module_select),
    .port_chip_select_n(cs_n), .host_data_strobe_a(ds_a_n),
    .host_data_strobe_b(ds_b_n), .host_addr_strobe_n(as_n),
    .host_read_write_sel(rw), .reg_select_bit0(sel[0]),
    .reg_select_bit1(sel[1]), .host_addr_bus(bus),
    .emul_output_disable_n(emul_output_disable_n),
    .host_irq_req(host_irq_req), .timer_b_output(timer_b_output),
    .timer_pin_sel(timer_pin_sel), .core_ack(core_ack), .access(access),
    .host_address_reg(host_address_reg), .host_port_ready(host_port_ready),
    .host_irq_n(host_irq_n), .port_enabled(port_enabled),
    .pullup_en(pullup_en));
  hpc_host_model u_hpc_host_model (.mclk(mclk), .rdy(host_port_ready.out),
    .cs_n(cs_n), .ds_a_n(ds_a_n), .ds_b_n(ds_b_n), .as_n(as_n), .rw(rw),
    .sel(sel), .bus(bus));
  // Clock, 20 ns period
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Core model: counts access pulses, acks three cycles later
  always @(posedge mclk) begin
    core_ack <= 1'b0;
    if (access.valid === 1'b1) begin
      nval <= nval + 1;
      ack_cnt <= 3;
    end else if (ack_cnt != 0) begin
      ack_cnt <= ack_cnt - 1;
      core_ack <= (ack_cnt == 1);
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // Bound on the whole run
  initial begin
    #1ms;
    failures++;
    complete_run();
  end
  // Main sequence: reset values, enable latch and irq checks, table rows, then hand-written cases;
  // inputs change on the rising edge, outputs are read 1 ns after it
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("access", access, ACC_RST);
    chk("addr", host_address_reg, ADDR_RST);
    chk("ready", host_port_ready, {READY_RST, OE_RST});
    chk("enabled", port_enabled, ENABLED_RST);
    chk("pullup", pullup_en, PULLUP_RST);
    chk("irq held", host_irq_n.out, IRQ_N_RST);
    @(posedge mclk);
    device_reset_n <= 1'b1;
    #1;
    chk("irq in reset", host_irq_n, 2'b11);
    wait_n(3);
    chk("enabled", port_enabled, 1'b1);
    @(posedge mclk);
    port_module_select <= 1'b0;
    wait_n(2);
    chk("enabled", port_enabled, 1'b1);
    chk("pullup", pullup_en, 1'b0);
    chk("irq", host_irq_n, 2'b01);
    chk("ready", host_port_ready, 2'b11);
    @(posedge mclk);
    host_irq_req <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_hpc_host_model.addr_cycle(ROWS[i][15:0]);
      u_hpc_host_model.xfer(ROWS[i][18], ROWS[i][17:16], ok);
      #1;
      chk("ok", ok, 1'b1);
      chk("pulses", 16'(nval), 16'(i + 1));
      chk("write", access.write, ROWS[i][18]);
      chk("sel", access.sel, ROWS[i][17:16]);
      chk("addr", host_address_reg, ROWS[i][15:0]);
    end
    chk("irq idle", host_irq_n.out, 1'b1);
    @(posedge mclk);
    emul_output_disable_n <= 1'b0;
    wait_n(2);
    chk("ready oe", host_port_ready.oe, 1'b0);
    chk("irq oe", host_irq_n.oe, 1'b0);
    // Clock enable low must freeze the pins at their floated state
    @(posedge mclk);
    clk_en <= 1'b0;
    emul_output_disable_n <= 1'b1;
    wait_n(3);
    chk("frozen oe", host_port_ready.oe, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    wait_n(2);
    chk("ready oe", host_port_ready.oe, 1'b1);
    chk("irq oe", host_irq_n.oe, 1'b1);
    @(posedge mclk);
    host_irq_req <= 1'b1;
    device_reset_n <= 1'b0;
    wait_n(2);
    chk("irq held", host_irq_n, 2'b11);
    @(posedge mclk);
    device_reset_n <= 1'b1;
    wait_n(3);
    chk("enabled", port_enabled, 1'b0);
    chk("pullup", pullup_en, 1'b1);
    @(posedge mclk);
    port_module_select <= 1'b1;
    wait_n(3);
    chk("enabled", port_enabled, 1'b0);
    u_hpc_host_model.addr_cycle(16'h0F0F);
    u_hpc_host_model.xfer(1'b1, 2'b10, ok);
    #1;
    chk("ok", ok, 1'b0);
    chk("pulses", 16'(nval), 16'd8);
    chk("addr", host_address_reg, ROWS[7][15:0]);
    @(posedge mclk);
    timer_pin_sel <= 1'b1;
    for (int t = 1; t >= 0; t--) begin
      @(posedge mclk);
      timer_b_output <= t[0];
      wait_n(2);
      chk("timer", host_irq_n.out, t[0]);
    end
    // Mid-run reset: reset values, then the latch samples select again
    @(posedge mclk);
    sys_rst <= 1'b1;
    wait_n(2);
    chk("addr", host_address_reg, ADDR_RST);
    chk("irq", host_irq_n, {IRQ_N_RST, OE_RST});
    chk("ready", host_port_ready, {READY_RST, OE_RST});
    @(posedge mclk);
    sys_rst <= 1'b0;
    wait_n(2);
    chk("enabled", port_enabled, 1'b1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
